// >>> gdc_defs.vh
// Timing constants for the gate driver enable and fault reset controller
`ifndef GDC_DEFS_VH
`define GDC_DEFS_VH

// Clock period in ns (10 MHz)
`define GDC_CLK_NS            100
// Input deglitch time in ns; pulses we drive must exceed it
`define GDC_DEGLITCH_NS       40
// Fault mute interval in ns (not printed; neutral default)
`define GDC_MUTE_NS           20000
// Reset filter interval in ns (not printed; neutral default)
`define GDC_RSTFIL_NS         2000
// Least-time cycle counts, rounded up
`define GDC_DEGLITCH_CYC      ((`GDC_DEGLITCH_NS + `GDC_CLK_NS - 1) / `GDC_CLK_NS)
`define GDC_MUTE_CYC          ((`GDC_MUTE_NS + `GDC_CLK_NS - 1) / `GDC_CLK_NS)
`define GDC_RSTFIL_CYC        ((`GDC_RSTFIL_NS + `GDC_CLK_NS - 1) / `GDC_CLK_NS)
// Counter width
`define GDC_CNT_W             16

`endif

// >>> gdc_gate_driver_ctrl.v
// Host-side controller for the gate driver reset/enable and PWM pins
`timescale 1ns/1ps
`include "gdc_defs.vh"

module gdc_gate_driver_ctrl #(
    parameter [`GDC_CNT_W-1:0] MUTE_CYC   = `GDC_MUTE_CYC,
    parameter [`GDC_CNT_W-1:0] RSTFIL_CYC = `GDC_RSTFIL_CYC,
    parameter [`GDC_CNT_W-1:0] MINPW_CYC  = `GDC_DEGLITCH_CYC
) (
    input  wire mclk,
    input  wire rst,
    input  wire enableReq,
    input  wire autoReset,
    input  wire pwmInverted,
    input  wire pwmIn,
    input  wire clearReq,
    input  wire faultPin_n,
    input  wire readyPin,
    output reg  resetEnableOut,
    output reg  resetEnableOe_n,
    output reg  pwmPos,
    output reg  pwmNeg,
    output reg  faultSeen,
    output reg  readySeen,
    output reg  busy
);

    // Sequencer states, one-hot:
    // OFF  - pin driven low, driver disabled; leaves when enabled and no fault.
    // RUN  - pin high, or following the PWM level when automatic reset is on.
    // MUTE - a fault is latched; the pin stays high for the whole mute wait.
    //        A low pulse sent now would be thrown away by the driver, and the
    //        user would believe the fault had been cleared.
    // HOLD - pin low for the reset filter time, never below the deglitch floor.
    // WAIT - pin back to the enable request; waits until the fault pin releases.
    // In automatic reset mode the PWM low phase does the clearing, so RUN never
    // hands over to MUTE there. The user must keep the PWM low time above the
    // filter time; this block cannot stretch it without distorting the PWM.
    // Limitation: the mute wait starts when the synchronised fault is seen,
    // two to three clocks after the driver latched, so the controller always
    // waits slightly longer than the driver needs. That margin is deliberate.
    localparam [4:0] ST_OFF  = 5'b0_0001;
    localparam [4:0] ST_RUN  = 5'b0_0010;
    localparam [4:0] ST_MUTE = 5'b0_0100;
    localparam [4:0] ST_HOLD = 5'b0_1000;
    localparam [4:0] ST_WAIT = 5'b1_0000;

    reg  [4:0]            state;
    reg  [4:0]            next_state;
    reg  [`GDC_CNT_W-1:0] cnt;
    reg  [`GDC_CNT_W-1:0] next_cnt;
    reg  [1:0]            faultSync;
    reg  [1:0]            readySync;
    reg                   faultPending;
    reg                   next_faultPending;
    reg                   next_rstEn;
    wire                  faultNow;
    wire                  autoLevel;

    // Sequencing states; the user sees these as busy
    function gdcInSequence;
        input [4:0] st;
        begin
            gdcInSequence = st[2] | st[3] | st[4];
        end
    endfunction

    // Reset low time: the longer of the filter time and the deglitch floor,
    // so a short filter setting can never produce a pulse the driver rejects
    function [`GDC_CNT_W-1:0] gdcHoldLen;
        input [`GDC_CNT_W-1:0] filCyc;
        input [`GDC_CNT_W-1:0] minCyc;
        begin
            if (filCyc > minCyc) begin
                gdcHoldLen = filCyc;
            end else begin
                gdcHoldLen = minCyc;
            end
        end
    endfunction

    // Pins from the isolated side are asynchronous: two flops first
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            faultSync <= 2'b11;
            readySync <= 2'b00;
        end else begin
            faultSync <= {faultSync[0], faultPin_n};
            readySync <= {readySync[0], readyPin};
        end
    end

    assign faultNow  = ~faultSync[1];
    // Inverting PWM gets a NOT before reset/enable
    assign autoLevel = pwmInverted ? ~pwmIn : pwmIn;

    // Sequencer: mute wait, timed low pulse, then release
    always @* begin
        next_state        = state;
        next_cnt          = cnt;
        // Pending is set only when a manual clear sequence starts, and cleared
        // at the end of the low pulse; a fault pin still low in WAIT must not
        // set it again, or faultSeen would stick after the driver released
        next_faultPending = faultPending;
        next_rstEn        = 1'b0;
        case (state)
            ST_OFF: begin
                next_rstEn = 1'b0;
                if (enableReq && !faultNow) begin
                    next_state = ST_RUN;
                end
            end
            ST_RUN: begin
                next_rstEn = autoReset ? autoLevel : 1'b1;
                if (!enableReq) begin
                    next_state = ST_OFF;
                end else if (faultNow && !autoReset) begin
                    // Fault latched by the driver: start the mute wait
                    next_state        = ST_MUTE;
                    next_cnt          = MUTE_CYC;
                    next_faultPending = 1'b1;
                end
            end
            ST_MUTE: begin
                // Keep pin high: a low here would be ignored anyway
                next_rstEn = 1'b1;
                if (cnt > 1) begin
                    next_cnt = cnt - 1'b1;
                end else if (clearReq || !enableReq) begin
                    // Mute over and the user asks for a clear, or disables
                    next_state = ST_HOLD;
                    next_cnt   = gdcHoldLen(RSTFIL_CYC, MINPW_CYC);
                end
            end
            ST_HOLD: begin
                next_rstEn = 1'b0;
                if (cnt > 1) begin
                    next_cnt = cnt - 1'b1;
                end else begin
                    // Low pulse complete; the driver clears on the rising edge
                    next_state        = ST_WAIT;
                    next_faultPending = 1'b0;
                end
            end
            ST_WAIT: begin
                // Pin follows the request; run again once the fault pin is high
                next_rstEn = enableReq;
                if (!enableReq) begin
                    next_state = ST_OFF;
                end else if (!faultNow) begin
                    next_state = ST_RUN;
                end
            end
            default: begin
                next_state = ST_OFF;
            end
        endcase
    end

    // State and pin registers; every output straight from a flop
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            state           <= ST_OFF;
            cnt             <= {`GDC_CNT_W{1'b0}};
            faultPending    <= 1'b0;
            resetEnableOut  <= 1'b0;
            resetEnableOe_n <= 1'b0;
            pwmPos          <= 1'b0;
            pwmNeg          <= 1'b0;
            faultSeen       <= 1'b0;
            readySeen       <= 1'b0;
            busy            <= 1'b0;
        end else begin
            state           <= next_state;
            cnt             <= next_cnt;
            faultPending    <= next_faultPending;
            resetEnableOut  <= next_rstEn;
            resetEnableOe_n <= 1'b0;                         // Always driven, never left to pulldown
            // PWM goes to the non-inverting input when pwmInverted is low, to the inverting input when it is high; the other input is held low
            pwmPos          <= pwmIn & ~pwmInverted;
            pwmNeg          <= pwmIn & pwmInverted;
            faultSeen       <= faultNow | next_faultPending;
            readySeen       <= readySync[1];
            // Busy decoded from the next state so it lines up with the state
            busy            <= gdcInSequence(next_state);
        end
    end

endmodule // gdc_gate_driver_ctrl

// >>> gdc_dev_model.sv
// Behavioural model of the gate driver as seen from its input pins
`timescale 1ns/1ps
module gdc_dev_model #(parameter integer MUTE = 4, parameter integer FIL = 3) (
    input  wire mclk, rstEn, inPos, inNeg, desaturation_sense,
    output wire faultPin_n, readyPin, gateOut
);
    reg     latched = 1'b0;
    integer muteCnt = 0, lowCnt = 0;
    // Sampled once a cycle, so pulses below the deglitch time never act
    always @(posedge mclk) begin
        muteCnt <= latched ? muteCnt + 1 : 0;
        // Low time counts only after mute, so an early pulse is ignored
        lowCnt <= (rstEn || muteCnt < MUTE) ? 0 : lowCnt + 1;
        if (!latched && rstEn && desaturation_sense) latched <= 1'b1;
        else if (latched && rstEn && lowCnt >= FIL) latched <= 1'b0;
    end
    // Gate runs only enabled, unlatched and not interlocked
    assign gateOut = rstEn && !latched && inPos && !inNeg;
    // Released open-drain pins read high through pullups
    assign faultPin_n = latched ? 1'b0 : 1'b1;
    assign readyPin = 1'b1;
endmodule // gdc_dev_model

// >>> gdc_gate_driver_ctrl_checker.sv
// Port checks for the gate driver controller
`timescale 1ns/1ps
module gdc_gate_driver_ctrl_checker #(
    parameter [15:0] MUTE_CYC = 16'h00C8, RSTFIL_CYC = 16'h0014, MINPW_CYC = 16'h0001
) (
    input wire mclk, rst, enableReq, autoReset, pwmInverted, pwmIn, clearReq, faultPin_n,
    input wire readyPin, resetEnableOut, resetEnableOe_n, pwmPos, pwmNeg, faultSeen,
    input wire readySeen, busy
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    reg [7:0] lowCnt, busyCnt;
    // Run lengths of pin low and of busy, saturating
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            lowCnt <= 8'h00;
            busyCnt <= 8'h00;
        end else begin
            lowCnt <= resetEnableOut ? 8'h00 : lowCnt + {7'h00, lowCnt != 8'hFF};
            busyCnt <= busy ? busyCnt + {7'h00, busyCnt != 8'hFF} : 8'h00;
        end
    end
    AST_PWM_POS:
        assert property (!$past(rst) |-> pwmPos == ($past(pwmIn) && !$past(pwmInverted)))
        else $error("pwmPos mismatch");
    AST_PWM_NEG:
        assert property (!$past(rst) |-> pwmNeg == ($past(pwmIn) && $past(pwmInverted)))
        else $error("pwmNeg mismatch");
    AST_AUTO_PIN:
        assert property ((autoReset && enableReq && $stable(pwmIn) && $stable(pwmInverted))[*3]
            |-> resetEnableOut == (pwmIn ^ pwmInverted)) else $error("auto pin mismatch");
    AST_HOLD_LEN:
        assert property ($rose(resetEnableOut) && $past(busy) && !autoReset
            |-> lowCnt >= RSTFIL_CYC) else $error("reset pulse too short");
    AST_MUTE_FIRST:
        assert property (busy && !resetEnableOut && !autoReset |-> busyCnt >= MUTE_CYC)
        else $error("reset pulse inside mute");
    AST_DRIVE:
        assert property (!$past(rst) |-> !resetEnableOe_n) else $error("pin not driven");
    // Main scenarios
    cover property (busy && !resetEnableOut);
    cover property (autoReset && pwmInverted && resetEnableOut);
    cover property ($fell(faultSeen));
endmodule // gdc_gate_driver_ctrl_checker
bind gdc_gate_driver_ctrl gdc_gate_driver_ctrl_checker #(.MUTE_CYC(MUTE_CYC),
    .RSTFIL_CYC(RSTFIL_CYC), .MINPW_CYC(MINPW_CYC)) chk_i (.mclk, .rst, .enableReq,
    .autoReset, .pwmInverted, .pwmIn, .clearReq, .faultPin_n, .readyPin, .resetEnableOut,
    .resetEnableOe_n, .pwmPos, .pwmNeg, .faultSeen, .readySeen, .busy);

// >>> gdc_gate_driver_ctrl_tb.sv
// Testbench for the gate driver enable and fault reset controller
`timescale 1ns/1ps
module gdc_gate_driver_ctrl_tb;
    reg     mclk = 0, rst = 1, enableReq = 0, autoReset = 0, pwmInverted = 0, pwmIn = 0;
    reg     clearReq = 0, desaturation_sense = 0;
    wire    resetEnableOut, resetEnableOe_n, pwmPos, pwmNeg, faultSeen, readySeen, busy;
    wire    faultPin_n, readyPin, gateOut;
    integer error_cnt = 0, checked = 0, i;
    // Released pin falls to the device pulldown
    wire    pinLvl = resetEnableOe_n ? 1'b0 : resetEnableOut;
    always #50 mclk = ~mclk;
    gdc_gate_driver_ctrl #(.MUTE_CYC(16'h0004), .RSTFIL_CYC(16'h0003)) uut (.mclk, .rst,
        .enableReq, .autoReset, .pwmInverted, .pwmIn, .clearReq, .faultPin_n, .readyPin,
        .resetEnableOut, .resetEnableOe_n, .pwmPos, .pwmNeg, .faultSeen, .readySeen, .busy);
    gdc_dev_model dev (.mclk, .rstEn(pinLvl), .inPos(pwmPos), .inNeg(pwmNeg), .desaturation_sense,
        .faultPin_n, .readyPin, .gateOut);
    task chk(input [63:0] nm, input exp, input got);
        begin
            checked = checked + 1;
            if (got !== exp) begin
                error_cnt = error_cnt + 1;
                $display("[ERR] %0s exp %b got %b", nm, exp, got);
            end
        end
    endtask
    task cyc(input integer n);
        repeat (n) @(posedge mclk);
    endtask
    // Clear request held through mute must wait for it
    task s_manual;
        begin
            enableReq <= 1; pwmIn <= 1; cyc(4);
            chk("gate", 1'b1, gateOut);
            desaturation_sense <= 1; clearReq <= 1; cyc(1); desaturation_sense <= 0; cyc(4);
            chk("seen", 1'b1, faultSeen);
            chk("pinmute", 1'b1, pinLvl);
            for (i = 0; i < 40 && busy !== 1'b0; i = i + 1) cyc(1);
            clearReq <= 0; cyc(6);
            chk("fault_n", 1'b1, faultPin_n);
            chk("gate", 1'b1, gateOut);
            chk("seen", 1'b0, faultSeen);
        end
    endtask
    // PWM low phase of 6 cycles outlasts the filter of 3
    task s_auto(input inv);
        begin
            pwmInverted <= inv; autoReset <= 1; cyc(2);
            for (i = 0; i < 3; i = i + 1) begin
                pwmIn <= ~inv; desaturation_sense <= (i == 0); cyc(6);
                desaturation_sense <= 0;
                if (i == 0) chk("latched", 1'b0, faultPin_n);
                pwmIn <= inv; cyc(6);
            end
            chk("autoclr", 1'b1, faultPin_n);
            autoReset <= 0; pwmInverted <= 0; pwmIn <= 1; cyc(4);
        end
    endtask
    task report_and_stop;
        begin
            $display("checks %0d errors %0d", checked, error_cnt);
            if (error_cnt == 0 && checked > 0) $display("== PASSED ==");
            else $display("== FAILED ==");
            $finish;
        end
    endtask
    initial begin
        cyc(20); rst <= 0; cyc(5);
        chk("ready", 1'b1, readySeen);
        s_manual;
        s_auto(1'b0);
        s_auto(1'b1);
        report_and_stop;
    end
    // Whole run needs about 140 cycles
    initial begin
        repeat (1000) @(posedge mclk);
        error_cnt = error_cnt + 1;
        report_and_stop;
    end
endmodule // gdc_gate_driver_ctrl_tb
